// file: fmu_pkg.sv
// Constants, state codes and carrier types for the float arithmetic unit.
// Assumes a 16-bit processor whose sequencer offers instruction words.
package fmu_pkg;
  // Instruction decode fields
  localparam logic [7:0] FMU_LOW_BYTE = 8'h39;
  localparam logic [3:0] FMU_ARITH_NIB = 4'hF;
  localparam logic [7:0] FMU_U2F_HI = 8'hF8;
  localparam logic [7:0] FMU_FIX_HI = 8'hE8;
  localparam logic [1:0] FN_ADD = 2'h0;
  localparam logic [1:0] FN_SUB = 2'h1;
  localparam logic [1:0] FN_MUL = 2'h2;
  localparam logic [1:0] FN_DIV = 2'h3;
  // Leading word layout: sign, 7-bit exponent, top 8 mantissa bits
  localparam int SIGN_POS = 15;
  localparam int EXP_MSB = 14;
  localparam int EXP_LSB = 8;
  localparam int MANT_MSB = 7;
  // Exponent limits, excess-64 power of sixteen
  localparam logic signed [9:0] EXP_BIAS = 10'sh040;
  localparam logic signed [9:0] EXP_MAX = 10'sh07F;
  localparam logic [6:0] FIX_EXP_MAX = 7'h44;
  localparam logic [6:0] FIX_EXP_MIN = 7'h40;
  localparam logic signed [9:0] U2F_EXP = 10'sh044;
  // Word counts (last index) and divide steps
  localparam logic [1:0] LAST_SINGLE = 2'h1;
  localparam logic [1:0] LAST_DOUBLE = 2'h3;
  localparam logic [1:0] LAST_ONE = 2'h0;
  localparam logic [6:0] DIV_STEPS = 7'h40;
  localparam logic [15:0] RST_WORD = 16'h0000;

  typedef enum logic [7:0] {
    ST_IDLE = 8'h01,
    ST_RSRC = 8'h02,
    ST_RDST = 8'h04,
    ST_EXEC = 8'h08,
    ST_DIVL = 8'h10,
    ST_NORM = 8'h20,
    ST_WR = 8'h40,
    ST_FIN = 8'h80
  } fmu_state_e;

  // Memory port request, one word per access
  typedef struct packed {
    logic req;
    logic we;
    logic [15:0] addr;
    logic [15:0] wdata;
  } fmu_mem_s;
endpackage : fmu_pkg

// file: fmu_float_unit.sv
// Float arithmetic unit: decode, operand fetch, compute, result store.
// Assumes a sequencer on CLK that offers words and waits for DONE, and a
// memory that answers each held request with a one-cycle MEM_ACK.
// Functional notes
// - Single is two words, double four.
// - Leading word: sign, exponent, top mantissa byte.
// - Seven-bit excess-64 exponent, power of sixteen.
// - Inputs assumed normalized; results always normalized.
// - Leading word zero means whole operand zero.
// - Decode ten encodings with low byte 39h.
// - Fix truncates to unsigned word; float converts.
// - Without the option, encodings are skipping no-ops.
// - Source address accumulator zero, destination one.
// - Destination overwritten; source never written.
// - Other accumulators untouched; carry undefined.
// - Skip on success except float; no skip overflow.
// - Add, sub, mul overflow at sixteen power 63.
// - Divide overflows on zero divisor or range.
// - Fix overflows at 2^16; float never errs.
// - Underflow below 16^-65 stores zero, still skips.
// - Decode gated by extended instruction set enable.
`timescale 1ns/1ps
`default_nettype none
module fmu_float_unit #(
  parameter bit OPTION_FITTED = 1'b1
) (
  input wire logic CLK,
  input wire logic RST_N,
  input wire logic EXTENDED_INSTRUCTION_SET,
  input wire logic CMD_VALID,
  input wire logic [15:0] CMD_WORD,
  input wire logic [15:0] AC0,
  input wire logic [15:0] AC1,
  output logic CMD_CLAIM,
  output logic BUSY,
  output logic DONE,
  output logic SKIP,
  output fmu_pkg::fmu_mem_s MEM,
  input wire logic MEM_ACK,
  input wire logic [15:0] MEM_RDATA
);
  import fmu_pkg::*;

  fmu_state_e state_q;
  fmu_mem_s mem_q;
  logic claim_q, done_q, skip_q, busy_q, ovf_q;
  logic [1:0] idx_q;
  logic [15:0] ac1_q;
  logic [2:0] op_q;
  logic fix_q, u2f_q, zres_q, sgn_q;
  logic [15:0] sw_q [4];
  logic [15:0] dw_q [4];
  logic [63:0] wm_q, rem_q, dvs_q;
  logic signed [9:0] e_q;
  logic [6:0] cnt_q;

  // Decode: arithmetic nibble with bit 11 clear, or the two conversions
  logic hit_arith, hit_fix, hit_u2f, hit;
  assign hit_arith = CMD_WORD[7:0] == FMU_LOW_BYTE &&
                     CMD_WORD[15:12] == FMU_ARITH_NIB &&
                     !CMD_WORD[11];
  assign hit_fix = CMD_WORD[7:0] == FMU_LOW_BYTE &&
                   CMD_WORD[15:8] == FMU_FIX_HI;
  assign hit_u2f = CMD_WORD[7:0] == FMU_LOW_BYTE &&
                   CMD_WORD[15:8] == FMU_U2F_HI;
  assign hit = hit_arith || hit_fix || hit_u2f;

  logic dbl, conv;
  logic [1:0] fn, src_last, dst_last, wr_last;
  assign dbl = op_q[2] && !conv;
  assign fn = op_q[1:0];
  assign conv = fix_q || u2f_q;
  assign src_last = u2f_q ? LAST_ONE :
                    dbl ? LAST_DOUBLE : LAST_SINGLE;
  assign dst_last = dbl ? LAST_DOUBLE : LAST_SINGLE;
  assign wr_last = fix_q ? LAST_ONE : src_last == LAST_DOUBLE ?
                   LAST_DOUBLE : LAST_SINGLE;

  // Unpack operands; a single keeps its lower 32 mantissa bits zero
  logic [55:0] ma, mb;
  logic a_zero, b_zero, sa, sb;
  logic [9:0] ea, eb;
  assign ma = {dw_q[0][MANT_MSB:0], dw_q[1],
               dbl ? {dw_q[2], dw_q[3]} : 32'h0};
  assign mb = {sw_q[0][MANT_MSB:0], sw_q[1],
               dbl ? {sw_q[2], sw_q[3]} : 32'h0};
  assign a_zero = dw_q[0] == RST_WORD;
  assign b_zero = sw_q[0] == RST_WORD;
  assign sa = dw_q[0][SIGN_POS];
  assign sb = sw_q[0][SIGN_POS];
  assign ea = {3'h0, dw_q[0][EXP_MSB:EXP_LSB]};
  assign eb = {3'h0, sw_q[0][EXP_MSB:EXP_LSB]};

  // Add/sub: a zero operand borrows the other's exponent so alignment
  // leaves the nonzero one untouched
  logic [9:0] ea_x, eb_x, diff, e_add;
  logic [55:0] ma_x, mb_x;
  logic big, eff_sub, s_add;
  logic [63:0] w_big, w_sml, w_shf, w_sum;
  assign ea_x = a_zero ? eb : ea;
  assign eb_x = b_zero ? ea : eb;
  assign ma_x = a_zero ? 56'h0 : ma;
  assign mb_x = b_zero ? 56'h0 : mb;
  assign big = ea_x > eb_x || (ea_x == eb_x && ma_x >= mb_x);
  assign diff = big ? ea_x - eb_x : eb_x - ea_x;
  assign w_big = big ? {4'h0, ma_x, 4'h0} : {4'h0, mb_x, 4'h0};
  assign w_sml = big ? {4'h0, mb_x, 4'h0} : {4'h0, ma_x, 4'h0};
  assign w_shf = diff > 10'h00F ? 64'h0 : w_sml >> {diff[3:0], 2'h0};
  assign eff_sub = sa ^ sb ^ (fn == FN_SUB);
  assign w_sum = eff_sub ? w_big - w_shf : w_big + w_shf;
  assign s_add = big ? sa : sb ^ (fn == FN_SUB);
  assign e_add = big ? ea_x : eb_x;

  // Multiply keeps 60 fraction bits; the low guard nibble truncates
  logic [111:0] prod;
  assign prod = ma * mb;

  // Fix: exponents 64..68 shift the fraction left by whole nibbles
  logic [71:0] fix_sh;
  logic fix_ovf;
  logic [6:0] fe;
  assign fe = sw_q[0][EXP_MSB:EXP_LSB];
  assign fix_sh = {16'h0, mb} << {sw_q[0][10:8], 2'h0};
  assign fix_ovf = !b_zero && (sb || fe > FIX_EXP_MAX);

  // Normalizer status, one nibble per cycle
  logic norm_done, res_ovf;
  assign norm_done = wm_q[63:60] == 4'h0 &&
                     (wm_q == 64'h0 || wm_q[59:56] != 4'h0);
  assign res_ovf = norm_done && wm_q != 64'h0 && e_q > EXP_MAX;

  // Result words; zero result writes all zero words
  logic [15:0] rw [4];
  always_comb
  begin
    rw[0] = {sgn_q, e_q[6:0], wm_q[59:52]};
    rw[1] = wm_q[51:36];
    rw[2] = wm_q[35:20];
    rw[3] = wm_q[19:4];
    if (fix_q)
    begin
      rw[0] = wm_q[15:0];
    end
    else if (zres_q)
    begin
      rw[0] = RST_WORD;
      rw[1] = RST_WORD;
      rw[2] = RST_WORD;
      rw[3] = RST_WORD;
    end
  end

  // Sequencer: handshake, memory walk and completion
  always_ff @(posedge CLK)
  begin
    if (!RST_N)
    begin
      state_q <= ST_IDLE;
      mem_q <= '0;
      idx_q <= 2'h0;
      claim_q <= 1'b0;
      done_q <= 1'b0;
      skip_q <= 1'b0;
      busy_q <= 1'b0;
      ovf_q <= 1'b0;
    end
    else
    begin
      claim_q <= 1'b0;
      done_q <= 1'b0;
      case (state_q)
        ST_IDLE:
        begin
          // Requests while disabled are left to the processor
          if (CMD_VALID && EXTENDED_INSTRUCTION_SET && hit)
          begin
            claim_q <= 1'b1;
            busy_q <= 1'b1;
            ovf_q <= 1'b0;
            skip_q <= 1'b0;
            idx_q <= 2'h0;
            if (!OPTION_FITTED)
            begin
              state_q <= ST_FIN;
            end
            else
            begin
              mem_q <= '{1'b1, 1'b0, AC0, RST_WORD};
              state_q <= ST_RSRC;
            end
          end
        end
        ST_RSRC:
        begin
          if (MEM_ACK)
          begin
            mem_q.addr <= mem_q.addr + 16'h1;
            idx_q <= idx_q + 2'h1;
            if (idx_q == src_last)
            begin
              idx_q <= 2'h0;
              if (conv)
              begin
                mem_q.req <= 1'b0;
                state_q <= ST_EXEC;
              end
              else
              begin
                mem_q.addr <= ac1_q;
                state_q <= ST_RDST;
              end
            end
          end
        end
        ST_RDST:
        begin
          if (MEM_ACK)
          begin
            mem_q.addr <= mem_q.addr + 16'h1;
            idx_q <= idx_q + 2'h1;
            if (idx_q == dst_last)
            begin
              idx_q <= 2'h0;
              mem_q.req <= 1'b0;
              state_q <= ST_EXEC;
            end
          end
        end
        ST_EXEC:
        begin
          if (fix_q)
          begin
            ovf_q <= fix_ovf;
            state_q <= fix_ovf ? ST_FIN : ST_WR;
          end
          else if (!u2f_q && fn == FN_DIV && b_zero)
          begin
            ovf_q <= 1'b1;
            state_q <= ST_FIN;
          end
          else if (!u2f_q && fn == FN_DIV && !a_zero)
          begin
            state_q <= ST_DIVL;
          end
          else
          begin
            state_q <= ST_NORM;
          end
        end
        ST_DIVL:
        begin
          if (cnt_q == 7'h1)
          begin
            state_q <= ST_NORM;
          end
        end
        ST_NORM:
        begin
          if (res_ovf && !u2f_q)
          begin
            ovf_q <= 1'b1;
            state_q <= ST_FIN;
          end
          else if (norm_done)
          begin
            state_q <= ST_WR;
          end
        end
        ST_WR:
        begin
          // Writes go only to the destination; the source is read-only
          if (!mem_q.req)
          begin
            mem_q <= '{1'b1, 1'b1, ac1_q, rw[0]};
          end
          else if (MEM_ACK)
          begin
            mem_q.addr <= mem_q.addr + 16'h1;
            mem_q.wdata <= rw[idx_q + 2'h1];
            idx_q <= idx_q + 2'h1;
            if (idx_q == wr_last)
            begin
              mem_q <= '0;
              idx_q <= 2'h0;
              state_q <= ST_FIN;
            end
          end
        end
        ST_FIN:
        begin
          done_q <= 1'b1;
          busy_q <= 1'b0;
          skip_q <= !OPTION_FITTED || (!ovf_q && !u2f_q);
          state_q <= ST_IDLE;
        end
        default:
        begin
          state_q <= ST_IDLE;
          mem_q <= '0;
        end
      endcase
    end
  end

  // Operand capture from memory and command latch
  always_ff @(posedge CLK)
  begin
    if (!RST_N)
    begin
      op_q <= 3'h0;
      fix_q <= 1'b0;
      u2f_q <= 1'b0;
      ac1_q <= RST_WORD;
      for (int i = 0; i < 4; i++)
      begin
        sw_q[i] <= RST_WORD;
        dw_q[i] <= RST_WORD;
      end
    end
    else
    begin
      if (state_q == ST_IDLE && CMD_VALID && EXTENDED_INSTRUCTION_SET && hit)
      begin
        op_q <= CMD_WORD[10:8];
        fix_q <= hit_fix;
        u2f_q <= hit_u2f;
        ac1_q <= AC1;
        for (int i = 0; i < 4; i++)
        begin
          sw_q[i] <= RST_WORD;
          dw_q[i] <= RST_WORD;
        end
      end
      if (state_q == ST_RSRC && MEM_ACK)
      begin
        sw_q[idx_q] <= MEM_RDATA;
      end
      if (state_q == ST_RDST && MEM_ACK)
      begin
        dw_q[idx_q] <= MEM_RDATA;
      end
    end
  end

  // Working mantissa, exponent, divider and normalizer
  always_ff @(posedge CLK)
  begin
    if (!RST_N)
    begin
      wm_q <= 64'h0;
      rem_q <= 64'h0;
      dvs_q <= 64'h0;
      e_q <= 10'sh000;
      cnt_q <= 7'h0;
      sgn_q <= 1'b0;
      zres_q <= 1'b0;
    end
    else if (state_q == ST_EXEC)
    begin
      zres_q <= 1'b0;
      if (fix_q)
      begin
        // Fraction below one truncates to zero
        wm_q <= (b_zero || fe < FIX_EXP_MIN) ? 64'h0 :
                {48'h0, fix_sh[71:56]};
      end
      else if (u2f_q)
      begin
        wm_q <= {4'h0, sw_q[0], 44'h0};
        e_q <= U2F_EXP;
        sgn_q <= 1'b0;
      end
      else
      begin
        case (fn)
          FN_ADD, FN_SUB:
          begin
            wm_q <= w_sum;
            e_q <= $signed(e_add);
            sgn_q <= s_add;
          end
          FN_MUL:
          begin
            wm_q <= (a_zero || b_zero) ? 64'h0 : {4'h0, prod[111:52]};
            e_q <= $signed(ea) + $signed(eb) - EXP_BIAS;
            sgn_q <= sa ^ sb;
          end
          default:
          begin
            // Restoring divide: 64 steps give 60 fraction bits
            wm_q <= 64'h0;
            rem_q <= {8'h0, ma};
            dvs_q <= {5'h0, mb, 3'h0};
            cnt_q <= DIV_STEPS;
            e_q <= $signed(ea) - $signed(eb) + EXP_BIAS;
            sgn_q <= sa ^ sb;
          end
        endcase
      end
    end
    else if (state_q == ST_DIVL)
    begin
      cnt_q <= cnt_q - 7'h1;
      if (rem_q >= dvs_q)
      begin
        rem_q <= {rem_q[62:0] - dvs_q[62:0], 1'b0};
        wm_q <= {wm_q[62:0], 1'b1};
      end
      else
      begin
        rem_q <= {rem_q[62:0], 1'b0};
        wm_q <= {wm_q[62:0], 1'b0};
      end
    end
    else if (state_q == ST_NORM)
    begin
      if (wm_q[63:60] != 4'h0)
      begin
        wm_q <= {4'h0, wm_q[63:4]};
        e_q <= e_q + 10'sh001;
      end
      else if (wm_q == 64'h0)
      begin
        zres_q <= 1'b1;
      end
      else if (wm_q[59:56] == 4'h0)
      begin
        wm_q <= {wm_q[59:0], 4'h0};
        e_q <= e_q - 10'sh001;
      end
      else if (e_q < 10'sh000)
      begin
        zres_q <= 1'b1;
      end
    end
  end

  // Outputs straight from flops; no accumulator or carry is driven
  assign CMD_CLAIM = claim_q;
  assign BUSY = busy_q;
  assign DONE = done_q;
  assign SKIP = skip_q;
  assign MEM = mem_q;

  if (OPTION_FITTED !== 1'b0 && OPTION_FITTED !== 1'b1)
  begin : g_chk
    $error("OPTION_FITTED must be 0 or 1");
  end
endmodule : fmu_float_unit
`default_nettype wire

// file: fmu_float_unit_monitor.sv
// Port checker for the float arithmetic unit, bound into every instance.
// Assumes one clock and the synchronous active-low reset.
`timescale 1ns/1ps
`default_nettype none
module fmu_float_unit_monitor #(
  parameter bit OPTION_FITTED = 1'b1
) (
  input wire logic CLK,
  input wire logic RST_N,
  input wire logic EXTENDED_INSTRUCTION_SET,
  input wire logic CMD_VALID,
  input wire logic [15:0] CMD_WORD,
  input wire logic [15:0] AC0,
  input wire logic [15:0] AC1,
  input wire logic CMD_CLAIM,
  input wire logic BUSY,
  input wire logic DONE,
  input wire logic SKIP,
  input wire fmu_pkg::fmu_mem_s MEM,
  input wire logic MEM_ACK,
  input wire logic [15:0] MEM_RDATA
);
  import fmu_pkg::*;
  logic take;
  logic [15:0] src_q;
  logic [15:0] dst_q;
  logic [15:0] word_q;
  default clocking cb @(posedge CLK);
  endclocking
  default disable iff (!RST_N);
  // Own decode, so a slip in the design's decode cannot hide
  assign take = CMD_VALID && EXTENDED_INSTRUCTION_SET && !BUSY &&
    CMD_WORD[7:0] == 8'h39 &&
    (CMD_WORD[15:11] == 5'h1E || CMD_WORD[15:8] == 8'hF8 ||
    CMD_WORD[15:8] == 8'hE8);
  // Addresses and word as offered at the taking edge
  always_ff @(posedge CLK)
  begin
    if (CMD_VALID && !BUSY)
    begin
      src_q <= AC0;
      dst_q <= AC1;
      word_q <= CMD_WORD;
    end
  end
  AST_CLAIM_CAUSE: assert property (
    CMD_CLAIM |-> $past(take)) else $error("claim without valid offer");
  AST_CLAIM_TAKEN: assert property (
    take |=> CMD_CLAIM && BUSY) else $error("valid offer not claimed");
  AST_DONE_BOUND: assert property (
    CMD_CLAIM |-> ##[1:400] DONE) else $error("command never finished");
  AST_DONE_SHAPE: assert property (
    DONE |-> (!BUSY && $past(BUSY)) ##1 !DONE) else $error("bad done");
  AST_U2F_NOSKIP: assert property (
    OPTION_FITTED && DONE && word_q[15:8] == 8'hF8 |-> !SKIP)
    else $error("float conversion skipped");
  AST_NOFIT_SKIP: assert property (
    !OPTION_FITTED && DONE |-> SKIP) else $error("unfitted no skip");
  AST_REQ_IN_BUSY: assert property (
    MEM.req |-> BUSY && OPTION_FITTED) else $error("stray memory access");
  AST_REQ_HOLD: assert property (
    MEM.req && !MEM_ACK |=> MEM.req && $stable(MEM.addr) &&
    $stable(MEM.we) && $stable(MEM.wdata)) else $error("request moved");
  AST_WR_STEP: assert property (
    MEM.req && MEM.we && MEM_ACK ##1 MEM.req |->
    MEM.we && MEM.addr == $past(MEM.addr) + 16'h0001)
    else $error("write address not stepped");
  AST_WR_DST: assert property (
    MEM.req && MEM.we |-> 16'(MEM.addr - dst_q) <=
    ((word_q[15:8] == 8'hE8) ? 16'h0000 : 16'h0003))
    else $error("write outside destination");
  AST_RD_REGION: assert property (
    MEM.req && !MEM.we |-> 16'(MEM.addr - src_q) <= 16'h0003 ||
    16'(MEM.addr - dst_q) <= 16'h0003) else $error("read out of range");
  COV_FLOAT: cover property (CMD_CLAIM && word_q[15:8] == 8'hF8);
  COV_SKIP: cover property (DONE && SKIP);
  COV_ERROR: cover property (OPTION_FITTED && DONE && !SKIP);
  COV_WRITE: cover property (MEM.req && MEM.we && MEM_ACK);
endmodule : fmu_float_unit_monitor
bind fmu_float_unit fmu_float_unit_monitor #(
  .OPTION_FITTED(OPTION_FITTED)
) i_mon (
  .CLK(CLK), .RST_N(RST_N), .CMD_VALID(CMD_VALID),
  .EXTENDED_INSTRUCTION_SET(EXTENDED_INSTRUCTION_SET),
  .CMD_WORD(CMD_WORD), .AC0(AC0), .AC1(AC1), .CMD_CLAIM(CMD_CLAIM),
  .BUSY(BUSY), .DONE(DONE), .SKIP(SKIP), .MEM(MEM), .MEM_ACK(MEM_ACK),
  .MEM_RDATA(MEM_RDATA)
);
`default_nettype wire

// file: fmu_mem_model.sv
// Word-wide main memory on the far side of the float unit.
// Assumes the unit holds each request until it sees the ack pulse.
`timescale 1ns/1ps
`default_nettype none
module fmu_mem_model (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [1:0] lat,
  input wire fmu_pkg::fmu_mem_s mem,
  output logic ack,
  output logic [15:0] rdata
);
  import fmu_pkg::*;
  logic [15:0] ram [0:255];
  logic [1:0] cnt;
  // One word per held request after lat idle cycles
  // Each signal gets one assignment per edge
  always @(posedge clk)
  begin
    if (!rst_n)
    begin
      cnt <= 2'h0;
      ack <= 1'b0;
      rdata <= 16'hA5A5;
    end
    else if (mem.req && !ack && cnt == lat)
    begin
      ack <= 1'b1;
      cnt <= 2'h0;
      if (mem.we)
      begin
        ram[mem.addr[7:0]] <= mem.wdata;
        rdata <= ~rdata;
      end
      else
      begin
        rdata <= ram[mem.addr[7:0]];
      end
    end
    else
    begin
      ack <= 1'b0;
      cnt <= (mem.req && !ack) ? cnt + 2'h1 : cnt;
      rdata <= ack ? rdata : ~rdata; // Stale data must never look valid
    end
  end
endmodule : fmu_mem_model
`default_nettype wire

// file: fmu_float_unit_tb.sv
// Self-checking bench for the float arithmetic unit.
// Assumes the memory model and the bound port checker beside it.
`timescale 1ns/1ps
`default_nettype none
module fmu_float_unit_tb;
  import fmu_pkg::*;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic extended_instruction_set = 1'b1;
  logic cmd_valid = 1'b0;
  logic [15:0] cmd_word = 16'h0000;
  logic [15:0] ac0 = 16'h0000;
  logic [15:0] ac1 = 16'h0000;
  logic [1:0] lat = 2'h0;
  logic claim, busy, done, skip, ack, nf_done, nf_skip;
  logic [15:0] rdata;
  fmu_mem_s mem, nf_mem;
  logic [31:0] rnd = 32'hDC09;
  int fail_count = 0;
  int checks_done = 0;
  int cyc = 0;

  always #2.5 clk = ~clk;

  fmu_float_unit i_dut (
    .CLK(clk), .RST_N(rst_n), .CMD_VALID(cmd_valid),
    .EXTENDED_INSTRUCTION_SET(extended_instruction_set),
    .CMD_WORD(cmd_word), .AC0(ac0), .AC1(ac1), .CMD_CLAIM(claim),
    .BUSY(busy), .DONE(done), .SKIP(skip), .MEM(mem), .MEM_ACK(ack),
    .MEM_RDATA(rdata)
  );
  // Same offers go to a unit built without the option
  fmu_float_unit #(.OPTION_FITTED(1'b0)) i_nofit (
    .CLK(clk), .RST_N(rst_n), .CMD_VALID(cmd_valid),
    .EXTENDED_INSTRUCTION_SET(extended_instruction_set),
    .CMD_WORD(cmd_word), .AC0(ac0), .AC1(ac1), .CMD_CLAIM(), .BUSY(),
    .DONE(nf_done), .SKIP(nf_skip), .MEM(nf_mem), .MEM_ACK(1'b0),
    .MEM_RDATA(16'h0000)
  );
  fmu_mem_model i_mem (
    .clk(clk), .rst_n(rst_n), .lat(lat), .mem(mem), .ack(ack),
    .rdata(rdata)
  );

  task automatic print_verdict();
    $display("checks %0d mismatches %0d", checks_done, fail_count);
    if (fail_count == 0 && checks_done > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask : print_verdict

  task automatic chk16(input logic [15:0] got, input logic [15:0] exp);
    checks_done++;
    if (got !== exp)
    begin
      fail_count++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk16

  task automatic chk1(input logic got, input logic exp);
    chk16({15'h0000, got}, {15'h0000, exp});
  endtask : chk1

  function automatic logic [31:0] lfsr(input logic [31:0] x);
    return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
  endfunction : lfsr

  // Unsigned word to normalised single: hex digits shift, exponent drops
  function automatic logic [31:0] u2f_of(input logic [15:0] u);
    logic [23:0] m;
    logic [6:0] e;
    m = {u, 8'h00};
    e = 7'h44;
    if (u == 16'h0000)
      return 32'h00000000;
    while (m[23:20] == 4'h0)
    begin
      m = m << 4;
      e = e - 7'h01;
    end
    return {1'b0, e, m};
  endfunction : u2f_of

  // Load operands, run one command, check skip and both operands
  task automatic do_cmd(input logic [15:0] w, input logic [63:0] d, s, e,
    input int nw, input logic sk);
    logic [15:0] sa;
    logic [15:0] da;
    logic [15:0] ew;
    int n;
    rnd = lfsr(rnd);
    if (w[10] == 1'b0)
    begin
      d[31:0] = rnd; // Tail words a single command must leave alone
      s[31:0] = ~rnd;
    end
    sa = {9'h000, rnd[6:0]};
    da = sa + 16'h0080;
    for (n = 0; n < 4; n++)
    begin
      i_mem.ram[8'(sa + n)] = s[63 - 16 * n -: 16];
      i_mem.ram[8'(da + n)] = d[63 - 16 * n -: 16];
    end
    @(posedge clk);
    lat <= rnd[9:8];
    cmd_valid <= 1'b1;
    cmd_word <= w;
    ac0 <= sa;
    ac1 <= da;
    @(posedge clk);
    cmd_valid <= 1'b0;
    n = 0;
    do
    begin
      @(negedge clk);
      n++;
    end
    while (done !== 1'b1 && n < 500);
    chk1(done, 1'b1);
    chk1(skip, sk);
    chk1(busy, 1'b0);
    for (n = 0; n < 4; n++)
    begin
      ew = (n < nw) ? e[63 - 16 * n -: 16] : d[63 - 16 * n -: 16];
      chk16(i_mem.ram[8'(da + n)], ew);
      chk16(i_mem.ram[8'(sa + n)], s[63 - 16 * n -: 16]);
    end
    $display("command %h finished", w);
  endtask : do_cmd

  task automatic run1(input logic [15:0] w, input logic [31:0] d, s, e,
    input int nw, input logic sk);
    do_cmd(w, {d, 32'h0}, {s, 32'h0}, {e, 32'h0}, nw, sk);
  endtask : run1

  // Offer a word that must not be claimed
  task automatic refuse(input logic [15:0] w, input logic en);
    @(posedge clk);
    extended_instruction_set <= en;
    cmd_valid <= 1'b1;
    cmd_word <= w;
    repeat (3)
    begin
      @(negedge clk);
      chk1(claim, 1'b0);
    end
    @(posedge clk);
    extended_instruction_set <= 1'b1;
    cmd_valid <= 1'b0;
    $display("refusal of %h finished", w);
  endtask : refuse

  // The unfitted unit skips every command it takes
  always @(negedge clk)
  begin
    if (nf_done === 1'b1)
    begin
      chk1(nf_skip, 1'b1);
      chk1(nf_mem.req, 1'b0);
    end
  end

  // Hang guard, far above the longest expected run
  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 40000)
    begin
      fail_count++;
      print_verdict();
    end
  end

  initial
  begin
    logic [15:0] u;
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    run1(16'hF039, 32'h42100000, 32'h41100000, 32'h42110000, 2, 1'b1);
    run1(16'hF139, 32'h42110000, 32'h42100000, 32'h41100000, 2, 1'b1);
    run1(16'hF239, 32'h41200000, 32'h41300000, 32'h41600000, 2, 1'b1);
    run1(16'hF339, 32'h41800000, 32'h41200000, 32'h41400000, 2, 1'b1);
    run1(16'hF039, 32'h7F800000, 32'h7F800000, 32'h0, 0, 1'b0);
    run1(16'hF239, 32'h7F100000, 32'h7F100000, 32'h0, 0, 1'b0);
    run1(16'hF339, 32'h41100000, 32'h0000FFFF, 32'h0, 0, 1'b0);
    run1(16'hF239, 32'h01100000, 32'h01100000, 32'h0, 2, 1'b1);
    run1(16'hE839, 32'h0, 32'h41500000, 32'h00050000, 1, 1'b1);
    run1(16'hE839, 32'h0, 32'h44FFFF00, 32'hFFFF0000, 1, 1'b1);
    run1(16'hE839, 32'h0, 32'h45100000, 32'h0, 0, 1'b0);
    run1(16'hE839, 32'h1, 32'h40800000, 32'h0, 1, 1'b1);
    run1(16'hF839, 32'h0, 32'h1234ABCD, 32'h44123400, 2, 1'b0);
    do_cmd(16'hF439, 64'h4110000000000001, 64'h4110000000000002,
      64'h4120000000000003, 4, 1'b1);
    do_cmd(16'hF539, 64'h42123456789ABCDE, 64'h42123456789ABCDE,
      64'h0, 4, 1'b1);
    do_cmd(16'hF639, 64'h4120000000000000, 64'h4130000000000000,
      64'h4160000000000000, 4, 1'b1);
    do_cmd(16'hF739, 64'h4180000000000000, 64'h4120000000000000,
      64'h4140000000000000, 4, 1'b1);
    do_cmd(16'hF439, 64'hC2123456789ABCDE, 64'h0000111122223333,
      64'hC2123456789ABCDE, 4, 1'b1);
    // Converted words widened to double with tails cleared by software
    do_cmd(16'hF439, 64'h4412340000000000, 64'h4410000000000000,
      64'h4422340000000000, 4, 1'b1);
    refuse(16'hF039, 1'b0);
    refuse(16'hF939, 1'b1);
    refuse(16'hF03A, 1'b1);
    // Random words through float and back again
    repeat (6)
    begin
      rnd = lfsr(rnd);
      u = rnd[31:16];
      run1(16'hF839, rnd, {u, 16'h0}, u2f_of(u), 2, 1'b0);
      run1(16'hE839, rnd, u2f_of(u), {u, 16'h0}, 1, 1'b1);
    end
    print_verdict();
  end
endmodule : fmu_float_unit_tb
`default_nettype wire
